// File: rtl/pinmux_pkg.sv
// shared constants, index maps and types for the port function multiplexer
package pinmux_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned NPORT = 5;
  localparam int unsigned NPIN  = 33;
  localparam int unsigned NIN   = 33;
  localparam int unsigned NOUT  = 21;
  localparam int unsigned AW    = 12;
  localparam int unsigned DW    = 32;
  localparam int unsigned FW    = 16;
  localparam int unsigned BW    = 8;
  localparam int unsigned PPP   = 8;

  // ****************************************
  // pin geometry
  // ****************************************
  localparam int unsigned P1_BIT  = 7;
  localparam int unsigned P5_IDX  = 4;
  localparam int unsigned P5_LO   = 3;
  localparam int unsigned P5_HI   = 6;
  localparam int unsigned FIRST_P = 2;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [AW-1:0] OFF_PORT1 = 12'h050;
  localparam logic [AW-1:0] OFF_PORT2 = 12'h0A0;
  localparam logic [AW-1:0] OFF_PORT3 = 12'h0F0;
  localparam logic [AW-1:0] OFF_PORT4 = 12'h140;
  localparam logic [AW-1:0] OFF_PORT5 = 12'h190;
  localparam logic [2:0]    IDX_NONE  = 3'h7;
  localparam logic [FW-1:0] RST_SEL   = 16'h0000;
  localparam logic [FW-1:0] RST_PORT2 = 16'h0010;

  // ****************************************
  // peripheral input indices
  // ****************************************
  localparam int unsigned I_EXT_INT1 = 0, I_EXT_INT2 = 1, I_EXT_INT5 = 2, I_EXT_INT6 = 3,
    I_EXT_INT7 = 4, I_EXT_INT8 = 5, I_EXT_INT9 = 6, I_BOOT_MODE = 7, I_SPI1_CS = 8,
    I_CONV_START = 9, I_CMP_IN2 = 10, I_LA_IN8 = 11, I_EXT_CLK = 12, I_CMP_IN3 = 13,
    I_LA_IN9 = 14, I_LA_IN10 = 15, I_SPI2_MOSI = 16, I_SPI2_MISO = 17, I_SPI2_SCLK = 18,
    I_SPI2_CS = 19, I_ADDR0 = 20, I_LA_IN12 = 21, I_ADDR1 = 22, I_PWM_SYNC = 23,
    I_LA_IN13 = 24, I_ADDR2 = 25, I_ADDR3 = 26, I_UART_RX = 27, I_LA_IN15 = 28,
    I_ADDR4 = 29, I_MDIO = 30, I_LA_IN11 = 31, I_LA_CLK2 = 32;

  // ****************************************
  // peripheral output indices
  // ****************************************
  localparam int unsigned O_SPI1_CS = 0, O_PWM5 = 1, O_LA_OUT13 = 2, O_RESET_OUT = 3,
    O_CLK_OUT = 4, O_TRACE = 5, O_SPI2_MOSI = 6, O_SPI2_MISO = 7, O_LA_OUT19 = 8,
    O_SPI2_SCLK = 9, O_LA_OUT20 = 10, O_SPI2_CS = 11, O_SLV_RDY0 = 12, O_UART_TX = 13,
    O_MGMT_CLK = 14, O_LA_OUT27 = 15, O_MDIO = 16, O_SLV_RDY2 = 17, O_LA_OUT30 = 18,
    O_PWM6 = 19, O_PWM7 = 20;

  // inactive levels: active-low selects and uart idle sit high
  localparam logic [NIN-1:0] IN_IDLE = (NIN'(1) << I_SPI1_CS) | (NIN'(1) << I_SPI2_CS)
    | (NIN'(1) << I_UART_RX);

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic o;
    logic oe_n;
  } pad_t;

  localparam pad_t PAD_OFF = '{o: 1'b0, oe_n: 1'b1};

  typedef struct packed {
    logic       gpio;
    logic       inp;
    logic [5:0] in_idx;
    logic       outp;
    logic [4:0] out_idx;
    logic       ana;
  } route_t;

  function automatic int unsigned pin_of(int unsigned port, int unsigned bit_n);
    return (port == 1) ? 0 : 1 + (port - FIRST_P) * PPP + bit_n;
  endfunction : pin_of

endpackage : pinmux_pkg

// File: rtl/gpio_port_function_mux.sv
// function multiplexer for port 1 pin 7 through port 5, with avalon register slave
// Notes on behaviour
// - p1.7: 0 gpio and interrupt 1, 1 spi1 select, 2 pwm5, 3 array out 13
// - p2.4 uses bits 9:8; 0 gpio, 1 spi2 mosi
// - p2.5 uses bits 11:10; 0 gpio, 1 spi2 miso, 3 array out 19
// - p2.6 uses bits 13:12; 0 gpio and interrupt 5, 1 spi2 clock, 3 out 20
// - p2.7 uses bits 15:14; 0 gpio and interrupt 6, 1 spi2 select
// - p3.3 uses bits 7:6; 1 address bit 3, 2 uart receive, 3 array in 15
// - p3.4 uses bits 9:8; 0 gpio and interrupt 9, 1 address 4, 2 uart transmit
// - port 2 pins 0 to 3 map converter, clock, comparator, boot and array functions
// - port 3 pins 0,1,2,5,6 map address, ready, sync, management clock, mdio
// - port 4 maps voltage outputs, array input 11, pwm6, pwm7, interrupt 7, clock 2
// - port 5 pins 0 to 2: 0 gpio, 2 voltage outputs 8, 9, 10
// - one port 5 field at 7:6 governs pins 3 to 6: gpio or output 11
// - p2.1 and p2.3 return to reset behaviour on every reset
// - blank function codes connect no peripheral
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
module gpio_port_function_mux (
  input  logic                                        core_clk,
  input  logic                                        srst,
  input  logic [pinmux_pkg::AW-1:0]                   avs_address,
  input  logic                                        avs_read,
  input  logic                                        avs_write,
  input  logic [pinmux_pkg::DW-1:0]                   avs_writedata,
  input  logic [pinmux_pkg::DW/pinmux_pkg::BW-1:0]    avs_byteenable,
  output logic [pinmux_pkg::DW-1:0]                   avs_readdata,
  output logic                                        avs_waitrequest,
  input  logic [pinmux_pkg::NPIN-1:0]                 pin_in,
  output pinmux_pkg::pad_t [pinmux_pkg::NPIN-1:0]     pin_pad,
  output logic [pinmux_pkg::NPIN-1:0]                 pin_analog_sel,
  input  pinmux_pkg::pad_t [pinmux_pkg::NPIN-1:0]     gpio_drive,
  output logic [pinmux_pkg::NPIN-1:0]                 gpio_in,
  input  pinmux_pkg::pad_t [pinmux_pkg::NOUT-1:0]     alt_drive,
  output logic [pinmux_pkg::NIN-1:0]                  alt_in
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [pinmux_pkg::NPORT-1:0][pinmux_pkg::FW-1:0] sel;
    logic                                             waitreq;
    logic [pinmux_pkg::DW-1:0]                        rdata;
    pinmux_pkg::pad_t [pinmux_pkg::NPIN-1:0]          pad;
    logic [pinmux_pkg::NPIN-1:0]                      ana;
    logic [pinmux_pkg::NPIN-1:0]                      gin;
    logic [pinmux_pkg::NIN-1:0]                       ain;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [2:0] reg_index(logic [pinmux_pkg::AW-1:0] a);
    unique case (a)
      pinmux_pkg::OFF_PORT1: return 3'h0;
      pinmux_pkg::OFF_PORT2: return 3'h1;
      pinmux_pkg::OFF_PORT3: return 3'h2;
      pinmux_pkg::OFF_PORT4: return 3'h3;
      pinmux_pkg::OFF_PORT5: return 3'h4;
      default:               return pinmux_pkg::IDX_NONE;
    endcase
  endfunction : reg_index

  function automatic logic [1:0] code_of(
    logic [pinmux_pkg::NPORT-1:0][pinmux_pkg::FW-1:0] sel, int unsigned p);
    int unsigned port;
    int unsigned b;
    port = (p == 0) ? 0 : 1 + (p - 1) / pinmux_pkg::PPP;
    b    = (p == 0) ? pinmux_pkg::P1_BIT : (p - 1) % pinmux_pkg::PPP;
    if (port == pinmux_pkg::P5_IDX && b >= pinmux_pkg::P5_LO && b <= pinmux_pkg::P5_HI) begin
      b = pinmux_pkg::P5_LO;
    end
    return sel[port][2*b +: 2];
  endfunction : code_of

  function automatic logic [7:0] key(int unsigned port, int unsigned b, logic [1:0] c);
    return {6'(pinmux_pkg::pin_of(port, b)), c};
  endfunction : key

  function automatic pinmux_pkg::route_t r_in(int unsigned i, logic g);
    pinmux_pkg::route_t r;
    r        = '0;
    r.gpio   = g;
    r.inp    = 1'b1;
    r.in_idx = 6'(i);
    return r;
  endfunction : r_in

  function automatic pinmux_pkg::route_t r_out(int unsigned o);
    pinmux_pkg::route_t r;
    r         = '0;
    r.outp    = 1'b1;
    r.out_idx = 5'(o);
    return r;
  endfunction : r_out

  function automatic pinmux_pkg::route_t r_io(int unsigned i, int unsigned o);
    pinmux_pkg::route_t r;
    r        = r_out(o);
    r.inp    = 1'b1;
    r.in_idx = 6'(i);
    return r;
  endfunction : r_io

  function automatic pinmux_pkg::route_t r_ana();
    pinmux_pkg::route_t r;
    r     = '0;
    r.ana = 1'b1;
    return r;
  endfunction : r_ana

  // ****************************************
  // function table
  // ****************************************
  function automatic pinmux_pkg::route_t route(int unsigned p, logic [1:0] c);
    pinmux_pkg::route_t r;
    logic [7:0]         k;
    r      = '0;
    r.gpio = (c == 2'h0);
    k      = {6'(p), c};
    case (k)
      key(1, 7, 2'h0): r = r_in(pinmux_pkg::I_EXT_INT1, 1'b1);
      key(1, 7, 2'h1): r = r_io(pinmux_pkg::I_SPI1_CS, pinmux_pkg::O_SPI1_CS);
      key(1, 7, 2'h2): r = r_out(pinmux_pkg::O_PWM5);
      key(1, 7, 2'h3): r = r_out(pinmux_pkg::O_LA_OUT13);
      key(2, 0, 2'h1): r = r_in(pinmux_pkg::I_CONV_START, 1'b0);
      key(2, 0, 2'h2): r = r_in(pinmux_pkg::I_CMP_IN2, 1'b0);
      key(2, 0, 2'h3): r = r_in(pinmux_pkg::I_LA_IN8, 1'b0);
      key(2, 1, 2'h0): r = r_in(pinmux_pkg::I_EXT_INT2, 1'b1);
      key(2, 1, 2'h1): r = r_in(pinmux_pkg::I_EXT_CLK, 1'b0);
      key(2, 1, 2'h2): r = r_in(pinmux_pkg::I_CMP_IN3, 1'b0);
      key(2, 1, 2'h3): r = r_in(pinmux_pkg::I_LA_IN9, 1'b0);
      key(2, 2, 2'h1): r = r_out(pinmux_pkg::O_RESET_OUT);
      key(2, 2, 2'h2): r = r_out(pinmux_pkg::O_CLK_OUT);
      key(2, 2, 2'h3): r = r_out(pinmux_pkg::O_TRACE);
      key(2, 3, 2'h0): r = r_in(pinmux_pkg::I_BOOT_MODE, 1'b1);
      key(2, 3, 2'h3): r = r_in(pinmux_pkg::I_LA_IN10, 1'b0);
      key(2, 4, 2'h1): r = r_io(pinmux_pkg::I_SPI2_MOSI, pinmux_pkg::O_SPI2_MOSI);
      key(2, 5, 2'h1): r = r_io(pinmux_pkg::I_SPI2_MISO, pinmux_pkg::O_SPI2_MISO);
      key(2, 5, 2'h3): r = r_out(pinmux_pkg::O_LA_OUT19);
      key(2, 6, 2'h0): r = r_in(pinmux_pkg::I_EXT_INT5, 1'b1);
      key(2, 6, 2'h1): r = r_io(pinmux_pkg::I_SPI2_SCLK, pinmux_pkg::O_SPI2_SCLK);
      key(2, 6, 2'h3): r = r_out(pinmux_pkg::O_LA_OUT20);
      key(2, 7, 2'h0): r = r_in(pinmux_pkg::I_EXT_INT6, 1'b1);
      key(2, 7, 2'h1): r = r_io(pinmux_pkg::I_SPI2_CS, pinmux_pkg::O_SPI2_CS);
      key(3, 0, 2'h0): r = r_in(pinmux_pkg::I_EXT_INT8, 1'b1);
      key(3, 0, 2'h1): r = r_in(pinmux_pkg::I_ADDR0, 1'b0);
      key(3, 0, 2'h2): r = r_out(pinmux_pkg::O_SLV_RDY0);
      key(3, 0, 2'h3): r = r_in(pinmux_pkg::I_LA_IN12, 1'b0);
      key(3, 1, 2'h1): r = r_in(pinmux_pkg::I_ADDR1, 1'b0);
      key(3, 1, 2'h2): r = r_in(pinmux_pkg::I_PWM_SYNC, 1'b0);
      key(3, 1, 2'h3): r = r_in(pinmux_pkg::I_LA_IN13, 1'b0);
      key(3, 2, 2'h1): r = r_in(pinmux_pkg::I_ADDR2, 1'b0);
      key(3, 3, 2'h1): r = r_in(pinmux_pkg::I_ADDR3, 1'b0);
      key(3, 3, 2'h2): r = r_in(pinmux_pkg::I_UART_RX, 1'b0);
      key(3, 3, 2'h3): r = r_in(pinmux_pkg::I_LA_IN15, 1'b0);
      key(3, 4, 2'h0): r = r_in(pinmux_pkg::I_EXT_INT9, 1'b1);
      key(3, 4, 2'h1): r = r_in(pinmux_pkg::I_ADDR4, 1'b0);
      key(3, 4, 2'h2): r = r_out(pinmux_pkg::O_UART_TX);
      key(3, 5, 2'h1): r = r_out(pinmux_pkg::O_MGMT_CLK);
      key(3, 5, 2'h3): r = r_out(pinmux_pkg::O_LA_OUT27);
      key(3, 6, 2'h1): r = r_io(pinmux_pkg::I_MDIO, pinmux_pkg::O_MDIO);
      key(3, 6, 2'h2): r = r_out(pinmux_pkg::O_SLV_RDY2);
      key(3, 6, 2'h3): r = r_out(pinmux_pkg::O_LA_OUT30);
      key(4, 0, 2'h1): r = r_ana();
      key(4, 0, 2'h3): r = r_in(pinmux_pkg::I_LA_IN11, 1'b0);
      key(4, 1, 2'h1): r = r_ana();
      key(4, 2, 2'h1): r = r_ana();
      key(4, 3, 2'h2): r = r_out(pinmux_pkg::O_PWM6);
      key(4, 4, 2'h1): r = r_ana();
      key(4, 5, 2'h2): r = r_out(pinmux_pkg::O_PWM7);
      key(4, 7, 2'h0): r = r_in(pinmux_pkg::I_EXT_INT7, 1'b1);
      key(4, 7, 2'h2): r = r_in(pinmux_pkg::I_LA_CLK2, 1'b0);
      key(5, 0, 2'h2): r = r_ana();
      key(5, 1, 2'h2): r = r_ana();
      key(5, 2, 2'h2): r = r_ana();
      key(5, 3, 2'h2): r = r_ana();
      key(5, 4, 2'h2): r = r_ana();
      key(5, 5, 2'h2): r = r_ana();
      key(5, 6, 2'h2): r = r_ana();
      default: ;
    endcase
    return r;
  endfunction : route

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    pinmux_pkg::route_t rt;
    logic [2:0]         ri;
    rt  = '0;
    ri  = reg_index(avs_address);
    s_d = s_q;
    // bus slave: one wait cycle, write lands on the completing edge
    if (!s_q.waitreq) begin
      s_d.waitreq = 1'b1;
      if (avs_write && ri != pinmux_pkg::IDX_NONE) begin
        for (int b = 0; b < pinmux_pkg::FW / pinmux_pkg::BW; b++) begin
          if (avs_byteenable[b]) begin
            s_d.sel[ri][b*pinmux_pkg::BW +: pinmux_pkg::BW] =
              avs_writedata[b*pinmux_pkg::BW +: pinmux_pkg::BW];
          end
        end
      end
    end else if (avs_read || avs_write) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = '0;
      if (avs_read && ri != pinmux_pkg::IDX_NONE) begin
        s_d.rdata[pinmux_pkg::FW-1:0] = s_q.sel[ri];
      end
    end
    // pin routing
    s_d.ain = pinmux_pkg::IN_IDLE;
    for (int unsigned p = 0; p < pinmux_pkg::NPIN; p++) begin
      rt          = route(p, code_of(s_q.sel, p));
      s_d.pad[p]  = pinmux_pkg::PAD_OFF;
      s_d.ana[p]  = rt.ana;
      s_d.gin[p]  = rt.gpio & pin_in[p];
      if (rt.gpio) begin
        s_d.pad[p] = gpio_drive[p];
      end else if (rt.outp) begin
        s_d.pad[p] = alt_drive[rt.out_idx];
      end
      if (rt.inp) begin
        s_d.ain[rt.in_idx] = pin_in[p];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q         <= '0;
      s_q.sel[1]  <= pinmux_pkg::RST_PORT2;
      s_q.waitreq <= 1'b1;
      s_q.pad     <= {pinmux_pkg::NPIN{pinmux_pkg::PAD_OFF}};
      s_q.ain     <= pinmux_pkg::IN_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign pin_pad         = s_q.pad;
  assign pin_analog_sel  = s_q.ana;
  assign gpio_in         = s_q.gin;
  assign alt_in          = s_q.ain;

  // ****************************************
  // checks
  // ****************************************
  localparam int unsigned P17 = pinmux_pkg::pin_of(1, 7);
  localparam int unsigned P21 = pinmux_pkg::pin_of(2, 1);
  localparam int unsigned P24 = pinmux_pkg::pin_of(2, 4);
  localparam int unsigned P25 = pinmux_pkg::pin_of(2, 5);
  localparam int unsigned P26 = pinmux_pkg::pin_of(2, 6);
  localparam int unsigned P27 = pinmux_pkg::pin_of(2, 7);
  localparam int unsigned P33 = pinmux_pkg::pin_of(3, 3);
  localparam int unsigned P34 = pinmux_pkg::pin_of(3, 4);
  localparam int unsigned P53 = pinmux_pkg::pin_of(5, 3);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence bus_req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence bus_done_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_handshake_a: assert property (bus_req_s |=> bus_done_s)
    else $error("bus answer not one cycle after request");

  p17_array_out_a: assert property (s_q.sel[0][15:14] == 2'h3 |=>
    pin_pad[P17] == $past(alt_drive[pinmux_pkg::O_LA_OUT13]))
    else $error("p1.7 code 3 does not carry array output 13");

  p24_mosi_a: assert property (s_q.sel[1][9:8] == 2'h1 |=>
    alt_in[pinmux_pkg::I_SPI2_MOSI] == $past(pin_in[P24]))
    else $error("p2.4 code 1 does not feed spi2 mosi");

  p25_array_out_a: assert property (s_q.sel[1][11:10] == 2'h3 |=>
    pin_pad[P25] == $past(alt_drive[pinmux_pkg::O_LA_OUT19]))
    else $error("p2.5 code 3 does not carry array output 19");

  p26_int_a: assert property (s_q.sel[1][13:12] == 2'h0 |=>
    alt_in[pinmux_pkg::I_EXT_INT5] == $past(pin_in[P26]) && gpio_in[P26] == $past(pin_in[P26]))
    else $error("p2.6 code 0 does not feed gpio and interrupt 5");

  p27_select_a: assert property (s_q.sel[1][15:14] != 2'h1 |=>
    alt_in[pinmux_pkg::I_SPI2_CS])
    else $error("spi2 select not idle high when unselected");

  p33_uart_rx_a: assert property (s_q.sel[2][7:6] == 2'h2 |=>
    alt_in[pinmux_pkg::I_UART_RX] == $past(pin_in[P33]))
    else $error("p3.3 code 2 does not feed uart receive");

  p34_uart_tx_a: assert property (s_q.sel[2][9:8] == 2'h2 |=>
    pin_pad[P34] == $past(alt_drive[pinmux_pkg::O_UART_TX]))
    else $error("p3.4 code 2 does not carry uart transmit");

  p5_shared_a: assert property (s_q.sel[4][7:6] == 2'h2 |=>
    pin_analog_sel[P53 +: 4] == 4'hF && pin_pad[P53].oe_n)
    else $error("port 5 shared field does not select output 11 on pins 3 to 6");

  na_undriven_a: assert property (s_q.sel[1][9:8] == 2'h2 |=> pin_pad[P24].oe_n
    && alt_in[pinmux_pkg::I_SPI2_MOSI] == 1'b0)
    else $error("blank code on p2.4 drives the pin");

  reset_return_a: assert property (@(posedge core_clk) disable iff (1'b0) srst |=>
    s_q.sel[1] == pinmux_pkg::RST_PORT2 && pin_pad[P21].oe_n)
    else $error("port 2 does not return to reset behaviour");

  reg_write_a: assert property (avs_write && !avs_waitrequest && avs_byteenable == 4'hF
    && avs_address == pinmux_pkg::OFF_PORT3 |=> s_q.sel[2] == $past(avs_writedata[15:0]))
    else $error("full write to port 3 select not stored");

endmodule : gpio_port_function_mux

// File: tb/pad_world.sv
// model of the package pins: pad drive wins, else the outside level
`timescale 1ns/100ps
module pad_world (
  input  pinmux_pkg::pad_t [pinmux_pkg::NPIN-1:0] pin_pad,
  input  logic [pinmux_pkg::NPIN-1:0]             ext_level,
  output logic [pinmux_pkg::NPIN-1:0]             pin_in
);
  // ****************************************
  // wire resolution
  // ****************************************
  always_comb begin
    for (int i = 0; i < pinmux_pkg::NPIN; i++) begin
      pin_in[i] = pin_pad[i].oe_n ? ext_level[i] : pin_pad[i].o;
    end
  end
endmodule : pad_world

// File: tb/gpio_port_function_mux_test.sv
// self-checking bench for the port function multiplexer
`timescale 1ns/100ps
module gpio_port_function_mux_test;
  localparam pinmux_pkg::pad_t HI = '{o: 1'b1, oe_n: 1'b0};
  localparam pinmux_pkg::pad_t LO = '{o: 1'b0, oe_n: 1'b0};
  localparam pinmux_pkg::pad_t GP = '{o: 1'b1, oe_n: 1'b1};
  logic                                    core_clk = 1'b0;
  logic                                    srst = 1'b1;
  logic [pinmux_pkg::AW-1:0]               avs_address = '0;
  logic                                    avs_read = 1'b0;
  logic                                    avs_write = 1'b0;
  logic [pinmux_pkg::DW-1:0]               avs_writedata = '0;
  logic [3:0]                              avs_byteenable = 4'h0;
  logic [pinmux_pkg::DW-1:0]               avs_readdata;
  logic                                    avs_waitrequest;
  logic [pinmux_pkg::NPIN-1:0]             pin_in, pin_analog_sel, gpio_in, ext_level;
  pinmux_pkg::pad_t [pinmux_pkg::NPIN-1:0] pin_pad, gpio_drive;
  pinmux_pkg::pad_t [pinmux_pkg::NOUT-1:0] alt_drive;
  logic [pinmux_pkg::NIN-1:0]              alt_in;
  logic [31:0]                             rd;
  int                                      n_errors = 0, comparisons = 0, cycles = 0;

  always #5 core_clk = ~core_clk;

  gpio_port_function_mux dut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_pad(pin_pad),
    .pin_analog_sel(pin_analog_sel), .gpio_drive(gpio_drive), .gpio_in(gpio_in),
    .alt_drive(alt_drive), .alt_in(alt_in));
  pad_world world (.pin_pad(pin_pad), .ext_level(ext_level), .pin_in(pin_in));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  always @(posedge core_clk) begin
    cycles++;
  end

  task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [11:0] addr, input logic [15:0] data,
                     input logic [3:0] be);
    @(posedge core_clk);
    avs_address    <= addr;
    avs_writedata  <= {16'h0000, data};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask : settle

  task automatic do_reset();
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(pin_pad, {pinmux_pkg::NPIN{pinmux_pkg::PAD_OFF}}, "pads in reset");
    check(alt_in, pinmux_pkg::IN_IDLE, "idle inputs in reset");
    check(pin_analog_sel, '0, "analog in reset");
    srst <= 1'b0;
  endtask : do_reset

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    bus(1'b1, pinmux_pkg::OFF_PORT2, 16'h00CC, 4'h3);
    bus(1'b1, pinmux_pkg::OFF_PORT1, 16'hC000, 4'h3);
    do_reset();
    bus(1'b0, pinmux_pkg::OFF_PORT2, 16'h0000, 4'h3);
    check(rd, 32'h0000_0010, "port2 after reset");
    bus(1'b0, pinmux_pkg::OFF_PORT1, 16'h0000, 4'h3);
    check(rd, 32'h0000_0000, "port1 after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_p17();
    pinmux_pkg::pad_t exp_pad [4];
    alt_drive[pinmux_pkg::O_SPI1_CS]  <= LO;
    alt_drive[pinmux_pkg::O_PWM5]     <= HI;
    alt_drive[pinmux_pkg::O_LA_OUT13] <= LO;
    exp_pad = '{GP, LO, HI, LO};
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, pinmux_pkg::OFF_PORT1, 16'(c) << 14, 4'h3);
      settle();
      check(pin_pad[0], exp_pad[c], "p1.7 pad");
      check(gpio_in[0], c == 0, "p1.7 gpio input");
      check(alt_in[pinmux_pkg::I_EXT_INT1], c == 0, "p1.7 interrupt");
      check(alt_in[pinmux_pkg::I_SPI1_CS], c != 1, "p1.7 select input");
    end
    $display("test port1 pin7 done");
  endtask : t_p17

  task automatic t_port2_3();
    alt_drive[pinmux_pkg::O_SPI2_MOSI] <= HI;
    alt_drive[pinmux_pkg::O_UART_TX]   <= HI;
    alt_drive[pinmux_pkg::O_MDIO]      <= HI;
    bus(1'b1, pinmux_pkg::OFF_PORT2, 16'h0210, 4'h3);
    settle();
    check(pin_pad[5], pinmux_pkg::PAD_OFF, "blank code drives");
    check(gpio_in[5], 1'b0, "blank code gpio input");
    bus(1'b1, pinmux_pkg::OFF_PORT2, 16'h0111, 4'h3);
    settle();
    check(pin_pad[5], HI, "spi2 mosi pad");
    check(alt_in[pinmux_pkg::I_CONV_START], 1'b1, "converter start follows pin");
    ext_level[12] <= 1'b0;
    bus(1'b1, pinmux_pkg::OFF_PORT3, 16'h1280, 4'hF);
    settle();
    check(alt_in[pinmux_pkg::I_UART_RX], 1'b0, "uart receive follows pin");
    check(pin_pad[15], HI, "mdio pad");
    check(alt_in[pinmux_pkg::I_MDIO], 1'b1, "mdio input follows pin");
    check(pin_pad[13], HI, "uart transmit pad");
    bus(1'b1, pinmux_pkg::OFF_PORT3, 16'h0000, 4'h3);
    settle();
    check(alt_in[pinmux_pkg::I_UART_RX], 1'b1, "uart receive idle");
    check(alt_in[pinmux_pkg::I_EXT_INT9], 1'b1, "p3.4 interrupt");
    ext_level[12] <= 1'b1;
    $display("test ports 2 and 3 done");
  endtask : t_port2_3

  task automatic t_port5();
    bus(1'b1, pinmux_pkg::OFF_PORT5, 16'h00A0, 4'h3);
    settle();
    check(pin_analog_sel, 33'h0F800_0000, "port5 analog pins");
    for (int i = 27; i < 32; i++) begin
      check(pin_pad[i], pinmux_pkg::PAD_OFF, "analog pin digital pad");
    end
    check(pin_pad[25], GP, "p5.0 gpio");
    alt_drive[pinmux_pkg::O_PWM6] <= HI;
    bus(1'b1, pinmux_pkg::OFF_PORT4, 16'h8081, 4'h3);
    settle();
    check(pin_analog_sel[17], 1'b1, "p4.0 voltage output");
    check(pin_pad[20], HI, "p4.3 pwm6 pad");
    check(alt_in[pinmux_pkg::I_LA_CLK2], 1'b1, "p4.7 array clock");
    check(alt_in[pinmux_pkg::I_EXT_INT7], 1'b0, "p4.7 interrupt idle");
    $display("test port5 done");
  endtask : t_port5

  task automatic t_regs();
    bus(1'b1, pinmux_pkg::OFF_PORT4, 16'hA5C3, 4'h3);
    bus(1'b1, pinmux_pkg::OFF_PORT4, 16'hFFFF, 4'h1);
    bus(1'b0, pinmux_pkg::OFF_PORT4, 16'h0000, 4'h3);
    check(rd, 32'h0000_A5FF, "byte lane write");
    bus(1'b1, 12'h004, 16'h1234, 4'h3);
    bus(1'b0, 12'h004, 16'h0000, 4'h3);
    check(rd, 32'h0000_0000, "unmapped read");
    $display("test registers done");
  endtask : t_regs

  initial begin
    ext_level  = '1;
    gpio_drive = {pinmux_pkg::NPIN{GP}};
    alt_drive  = {pinmux_pkg::NOUT{LO}};
    fork
      begin
        do_reset();
        t_reset();
        t_p17();
        t_port2_3();
        t_port5();
        t_regs();
      end
      begin
        wait (cycles >= 5000);
        n_errors++;
      end
    join_any
    final_report();
  end
endmodule : gpio_port_function_mux_test
